// File: sasc_map.vh
/*
 * Register map, field positions, reset values and timing counts of the
 * converter sequencer control block. Assumes inclusion by bare name.
 */
`ifndef SASC_MAP_VH
`define SASC_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SASC_OFF_CONVERTER_CONTROL_STATUS 8'h00
`define SASC_OFF_GLOB_CTRL 8'h04
`define SASC_OFF_INS_CHAN 8'h08
`define SASC_OFF_INS_SEQ 8'h0c
`define SASC_OFF_SLOTS_LOW 8'h18
`define SASC_OFF_SLOTS_HIGH 8'h1c
`define SASC_OFF_SEQ_FB 8'h50
`define SASC_OFF_GLOB_STS 8'h74

// ****************************************************************
// Field positions
// ****************************************************************
`define SASC_CS_PWR_BIT 0
`define SASC_CS_SOC_BIT 2
`define SASC_CS_EOC_BIT 3
`define SASC_CS_SEL_LO 4
`define SASC_CS_SEL_HI 6
`define SASC_GC_DIV_LO 0
`define SASC_GC_DIV_HI 5
`define SASC_GC_PWR_LO 8
`define SASC_GC_PWR_HI 9
`define SASC_GS_BUSY_BIT 0
`define SASC_GS_SAMP_BIT 1
`define SASC_GS_CHN_LO 3
`define SASC_GS_CHN_HI 5
`define SASC_FB_RUN_BIT 0
`define SASC_FB_SWMODE_BIT 8
`define SASC_FB_SUSP_BIT 9
`define SASC_IC_CHN_LO 0
`define SASC_IC_CHN_HI 2
`define SASC_IC_REP_LO 8
`define SASC_IC_REP_HI 14

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define SASC_RST_WORD 32'h0000_0000
`define SASC_SAMPLE_TICKS 8'h02
`define SASC_CONV_TICKS 8'h0a

`endif

// File: sasc_sequencer.v
/*
 * Converter sequencer control: Avalon-MM register slave, mode handling,
 * exceptional insertion priority with abort/resume, software conversion,
 * converter clock divider and live status.
 * Assumes trigger inputs synchronous to mclk_in, one-cycle pulses.
 */
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "sasc_map.vh"

module sasc_sequencer #(
    parameter SLOTS = 8
) (
    input wire mclk_in,
    input wire rst_n_in,
    input wire [7:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    input wire single_insert_in,
    input wire sequence_insert_in,
    input wire debug_suspend_in,
    output reg [2:0] conv_channel_out,
    output reg conv_sample_out,
    output reg conv_busy_out,
    output reg conv_done_out,
    output reg dma_req_out,
    output reg single_done_irq_out,
    output reg sequence_done_irq_out,
    output reg [1:0] analog_power_out,
    output reg power_up_out,
    output reg conv_clk_en_out
);

    // ****************************************************************
    // State encodings
    // ****************************************************************
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SAMP = 3'b010;
    localparam [2:0] ST_CONV = 3'b100;
    localparam [2:0] SRC_SEQ = 3'b001;
    localparam [2:0] SRC_INS = 3'b010;
    localparam [2:0] SRC_ESQ = 3'b100;

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg power_up_r;
    reg soc_r;
    reg eoc_r;
    reg [2:0] sw_sel_r;
    reg [1:0] apwr_r;
    reg [5:0] div_r;
    reg [2:0] ins_chn_r;
    reg [6:0] ins_rep_r;
    reg [7:0] ins_seq_r;
    reg [8*SLOTS-1:0] slots_r;
    reg run_r;
    reg swmode_r;
    reg [2:0] st_r;
    reg [2:0] src_r;
    reg [2:0] chn_r;
    reg [7:0] tick_r;
    reg [5:0] divcnt_r;
    reg [2:0] slot_r;
    reg [7:0] pend_r;
    reg [2:0] ipos_r;
    reg [7:0] ipend_r;
    reg [6:0] rep_r;
    reg esq_act_r;
    reg sus_r;
    reg pend_ins_r;
    reg pend_esq_r;

    // Highest set bit finds next channel, scanning LSB first so the last hit wins
    function [3:0] sasc_top;
        input [7:0] v;
        integer i;
        begin
            sasc_top = 4'h8;
            for (i = 0; i < 8; i = i + 1) begin
                if (v[i]) begin
                    sasc_top = {1'b0, i[2:0]};
                end
            end
        end
    endfunction

    // ****************************************************************
    // Decoding
    // ****************************************************************
    wire any_en = |slots_r;
    wire suspend = run_r && !swmode_r && !any_en;
    wire tick = (divcnt_r >= div_r); // At or past limit: a shrunk divider recovers
    wire acc = avs_read_in | avs_write_in;
    wire wr = avs_write_in && !avs_waitrequest_out && (&avs_byteenable_in);
    wire rd = avs_read_in && !avs_waitrequest_out;
    wire hw_ok = !swmode_r && !debug_suspend_in && any_en;
    wire [3:0] nxt_seq = sasc_top(pend_r);
    wire [3:0] nxt_esq = sasc_top(ipend_r);
    wire fin = (st_r == ST_CONV) && tick && (tick_r == `SASC_CONV_TICKS);
    wire ins_hit = (pend_ins_r || single_insert_in) && hw_ok;
    wire esq_hit = (pend_esq_r || sequence_insert_in) && hw_ok;
    wire [2:0] slot_inc = slot_r + 3'h1;

    // Read mux, unmapped offsets read zero
    reg [31:0] rdata;
    always @* begin
        rdata = `SASC_RST_WORD;
        case (avs_address_in)
            `SASC_OFF_CONVERTER_CONTROL_STATUS:
                rdata = {25'h0, sw_sel_r, eoc_r, soc_r, 1'b0, power_up_r};
            `SASC_OFF_GLOB_CTRL: rdata = {22'h0, apwr_r, 2'b00, div_r};
            `SASC_OFF_INS_CHAN: rdata = {17'h0, ins_rep_r, 5'h0, ins_chn_r};
            `SASC_OFF_INS_SEQ: rdata = {24'h0, ins_seq_r};
            `SASC_OFF_SLOTS_LOW: rdata = slots_r[31:0];
            `SASC_OFF_SLOTS_HIGH: rdata = slots_r[63:32];
            `SASC_OFF_SEQ_FB: rdata = {22'h0, suspend, swmode_r, 7'h0, run_r};
            `SASC_OFF_GLOB_STS:
                rdata = {22'h0, apwr_r, 2'b00, chn_r, 1'b0,
                    st_r == ST_SAMP, st_r != ST_IDLE};
            default: rdata = `SASC_RST_WORD;
        endcase
    end

    // ****************************************************************
    // Bus slave: one wait cycle, then answer
    // ****************************************************************
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            avs_waitrequest_out <= !(acc && avs_waitrequest_out);
            if (avs_read_in && avs_waitrequest_out) begin
                avs_readdata_out <= rdata;
            end
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            power_up_r <= 1'b0;
            sw_sel_r <= 3'h0;
            apwr_r <= 2'b00;
            div_r <= 6'h00;
            ins_chn_r <= 3'h0;
            ins_rep_r <= 7'h00;
            ins_seq_r <= 8'h00;
            slots_r <= {8*SLOTS{1'b0}};
        end else if (wr) begin
            case (avs_address_in)
                `SASC_OFF_CONVERTER_CONTROL_STATUS: begin
                    power_up_r <= avs_writedata_in[`SASC_CS_PWR_BIT];
                    sw_sel_r <= avs_writedata_in[`SASC_CS_SEL_HI:`SASC_CS_SEL_LO];
                end
                `SASC_OFF_GLOB_CTRL: begin
                    apwr_r <= avs_writedata_in[`SASC_GC_PWR_HI:`SASC_GC_PWR_LO];
                    div_r <= avs_writedata_in[`SASC_GC_DIV_HI:`SASC_GC_DIV_LO];
                end
                `SASC_OFF_INS_CHAN: begin
                    ins_chn_r <= avs_writedata_in[`SASC_IC_CHN_HI:`SASC_IC_CHN_LO];
                    ins_rep_r <= avs_writedata_in[`SASC_IC_REP_HI:`SASC_IC_REP_LO];
                end
                `SASC_OFF_INS_SEQ: ins_seq_r <= avs_writedata_in[7:0];
                `SASC_OFF_SLOTS_LOW: slots_r[31:0] <= avs_writedata_in;
                `SASC_OFF_SLOTS_HIGH: slots_r[63:32] <= avs_writedata_in;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Converter clock enable divider
    // ****************************************************************
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            divcnt_r <= 6'h00;
        end else begin
            divcnt_r <= tick ? 6'h00 : divcnt_r + 6'h01;
        end
    end

    // ****************************************************************
    // Conversion engine and sequencing
    // ****************************************************************
    // Insertion events are latched so one arriving mid-conversion
    // still aborts at the next decision point without being lost.
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_r <= 1'b0;
            swmode_r <= 1'b1;
            soc_r <= 1'b0;
            eoc_r <= 1'b0;
            st_r <= ST_IDLE;
            src_r <= SRC_SEQ;
            chn_r <= 3'h0;
            tick_r <= 8'h00;
            slot_r <= 3'h0;
            pend_r <= 8'h00;
            ipos_r <= 3'h0;
            ipend_r <= 8'h00;
            rep_r <= 7'h00;
            esq_act_r <= 1'b0;
            sus_r <= 1'b0;
            pend_ins_r <= 1'b0;
            pend_esq_r <= 1'b0;
            conv_done_out <= 1'b0;
            dma_req_out <= 1'b0;
            single_done_irq_out <= 1'b0;
            sequence_done_irq_out <= 1'b0;
        end else begin
            conv_done_out <= 1'b0;
            dma_req_out <= 1'b0;
            single_done_irq_out <= 1'b0;
            sequence_done_irq_out <= 1'b0;
            pend_ins_r <= ins_hit;
            pend_esq_r <= esq_hit;
            // Run bit write
            if (wr && avs_address_in == `SASC_OFF_SEQ_FB) begin
                run_r <= avs_writedata_in[`SASC_FB_RUN_BIT];
                if (avs_writedata_in[`SASC_FB_RUN_BIT] && !run_r) begin
                    swmode_r <= 1'b0;
                    slot_r <= 3'h0;
                    pend_r <= slots_r[7:0];
                end
            end
            // End flag clears on read, a same-cycle finish wins
            if (rd && avs_address_in == `SASC_OFF_CONVERTER_CONTROL_STATUS) begin
                eoc_r <= 1'b0;
            end
            if (!debug_suspend_in) begin
                sus_r <= 1'b0;
            end
            case (st_r)
                ST_IDLE: begin
                    tick_r <= 8'h00;
                    if (!run_r && !swmode_r) begin
                        swmode_r <= 1'b1;
                    end
                    if (ins_hit) begin
                        // Single insertion first
                        pend_ins_r <= 1'b0;
                        pend_esq_r <= esq_hit;
                        if (rep_r == 7'h00) begin
                            rep_r <= ins_rep_r;
                        end
                        src_r <= SRC_INS;
                        chn_r <= ins_chn_r;
                        st_r <= ST_SAMP;
                    end else if (rep_r != 7'h00 && !sus_r) begin
                        rep_r <= rep_r - 7'h01;
                        src_r <= SRC_INS;
                        chn_r <= ins_chn_r;
                        st_r <= ST_SAMP;
                    end else if (esq_hit && !esq_act_r) begin
                        pend_esq_r <= 1'b0;
                        esq_act_r <= 1'b1;
                        ipend_r <= ins_seq_r;
                    end else if (esq_act_r && !sus_r) begin
                        if (nxt_esq[3]) begin
                            esq_act_r <= 1'b0;
                            sequence_done_irq_out <= 1'b1;
                        end else begin
                            src_r <= SRC_ESQ;
                            chn_r <= nxt_esq[2:0];
                            st_r <= ST_SAMP;
                        end
                    end else if (!swmode_r && run_r && any_en && !sus_r) begin
                        if (nxt_seq[3]) begin
                            slot_r <= slot_inc;
                            pend_r <= slots_r[slot_inc*8 +: 8];
                        end else begin
                            src_r <= SRC_SEQ;
                            chn_r <= nxt_seq[2:0];
                            st_r <= ST_SAMP;
                        end
                    end else if (wr && avs_address_in == `SASC_OFF_CONVERTER_CONTROL_STATUS
                            && avs_writedata_in[`SASC_CS_SOC_BIT] && swmode_r
                            && !eoc_r) begin
                        // Ignored in suspend since swmode_r is low
                        soc_r <= 1'b1;
                        src_r <= SRC_SEQ;
                        chn_r <= avs_writedata_in[`SASC_CS_SEL_HI:`SASC_CS_SEL_LO];
                        st_r <= ST_SAMP;
                    end
                end
                ST_SAMP, ST_CONV: begin
                    // Abort: slot stays pending, nothing emitted
                    if (src_r != SRC_INS && !soc_r && (ins_hit || (esq_hit
                            && src_r == SRC_SEQ))) begin
                        st_r <= ST_IDLE;
                    end else begin
                        if (tick) begin
                            tick_r <= tick_r + 8'h01;
                            if (st_r == ST_SAMP && tick_r == `SASC_SAMPLE_TICKS) begin
                                st_r <= ST_CONV;
                            end
                        end
                        if (fin) begin
                            st_r <= ST_IDLE;
                            conv_done_out <= 1'b1;
                            dma_req_out <= 1'b1;
                            if (debug_suspend_in) begin
                                sus_r <= 1'b1;
                            end
                            if (soc_r) begin
                                soc_r <= 1'b0;
                                eoc_r <= 1'b1;
                            end else if (src_r == SRC_SEQ) begin
                                pend_r[chn_r] <= 1'b0;
                            end else if (src_r == SRC_ESQ) begin
                                ipend_r[chn_r] <= 1'b0;
                            end else if (rep_r == 7'h00) begin
                                single_done_irq_out <= 1'b1;
                            end
                        end
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Registered drive toward the analog core
    // ****************************************************************
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            conv_channel_out <= 3'h0;
            conv_sample_out <= 1'b0;
            conv_busy_out <= 1'b0;
            analog_power_out <= 2'b00;
            power_up_out <= 1'b0;
            conv_clk_en_out <= 1'b0;
        end else begin
            conv_channel_out <= chn_r;
            conv_sample_out <= (st_r == ST_SAMP);
            conv_busy_out <= (st_r != ST_IDLE);
            analog_power_out <= apwr_r;
            power_up_out <= power_up_r;
            conv_clk_en_out <= tick;
        end
    end

endmodule // sasc_sequencer

// File: sasc_sequencer_sva.sv
/* Checker for the converter sequencer control block.
   Assumes a bind onto sasc_sequencer and the single clock mclk_in. */
`timescale 1ns/10ps
module sasc_sequencer_sva #(
    parameter SLOTS = 8
) (
    input wire mclk_in,
    input wire rst_n_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    input wire [2:0] conv_channel_out,
    input wire conv_sample_out,
    input wire conv_busy_out,
    input wire conv_done_out,
    input wire dma_req_out,
    input wire single_done_irq_out,
    input wire [1:0] analog_power_out
);
    // ****
    // Port relations
    // ****
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // Bus answers exactly one cycle after a request is seen
    AST_BUS_ANSWER: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("bus answer late");
    AST_BUS_PULSE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    // Read data only moves on a read
    AST_RDATA_HOLD: assert property ($changed(avs_readdata_out) |-> $past(avs_read_in))
        else $error("read data moved without read");
    AST_DONE_DMA: assert property (conv_done_out |-> dma_req_out)
        else $error("done without dma request");
    AST_DONE_PULSE: assert property (conv_done_out |=> !conv_done_out)
        else $error("done longer than one cycle");
    // A finish must close a conversion that was running
    AST_DONE_AFTER_BUSY: assert property (conv_done_out
        |-> $past(conv_busy_out) || $past(conv_busy_out, 2)) else $error("done while idle");
    AST_CHAN_AT_START: assert property ($changed(conv_channel_out) |-> conv_sample_out)
        else $error("channel moved outside start");
    AST_IRQ_PULSE: assert property (single_done_irq_out |=> !single_done_irq_out)
        else $error("insert irq too long");
    // Power state only follows an accepted write
    AST_POWER_HOLD: assert property (!(avs_write_in && !avs_waitrequest_out)
        |-> ##2 $stable(analog_power_out)) else $error("power state moved without write");
endmodule // sasc_sequencer_sva

bind sasc_sequencer sasc_sequencer_sva #(.SLOTS(SLOTS)) sasc_sequencer_sva_inst (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .conv_channel_out(conv_channel_out),
    .conv_sample_out(conv_sample_out), .conv_busy_out(conv_busy_out),
    .conv_done_out(conv_done_out), .dma_req_out(dma_req_out),
    .single_done_irq_out(single_done_irq_out), .analog_power_out(analog_power_out));

// File: sasc_trigger_src.sv
/* Trigger sources and result consumer facing the sequencer.
   Assumes bench commands synchronous to mclk_in. */
`timescale 1ns/10ps
module sasc_trigger_src (
    input wire mclk_in,
    input wire rst_n_in,
    input wire [1:0] fire_in,
    input wire [2:0] conv_channel_in,
    input wire conv_sample_in,
    input wire dma_req_in,
    input wire single_done_irq_in,
    input wire sequence_done_irq_in,
    output reg single_insert_out,
    output reg sequence_insert_out,
    output reg [2:0] first_chan_out,
    output reg [7:0] dma_cnt_out,
    output reg [7:0] irq1_cnt_out,
    output reg [7:0] irq2_cnt_out
);
    // ****
    // Triggers and counters
    // ****
    reg armed_r;
    reg [2:0] chan_r;
    // One-cycle trigger pulses; first new channel after a trigger is kept
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {single_insert_out, sequence_insert_out, armed_r, chan_r} <= 6'h00;
            {first_chan_out, dma_cnt_out, irq1_cnt_out, irq2_cnt_out} <= 27'h0;
        end else begin
            single_insert_out <= fire_in[0];
            sequence_insert_out <= fire_in[1];
            dma_cnt_out <= dma_cnt_out + {7'h00, dma_req_in};
            irq1_cnt_out <= irq1_cnt_out + {7'h00, single_done_irq_in};
            irq2_cnt_out <= irq2_cnt_out + {7'h00, sequence_done_irq_in};
            if (single_insert_out || sequence_insert_out) begin
                armed_r <= 1'b1;
                chan_r <= conv_channel_in;
            end else if (armed_r && conv_sample_in && conv_channel_in != chan_r) begin
                first_chan_out <= conv_channel_in;
                armed_r <= 1'b0;
            end
        end
    end
endmodule // sasc_trigger_src

// File: sasc_sequencer_test.sv
/* Self-checking bench for the converter sequencer control block.
   Assumes sasc_sequencer, its bound checker and the trigger model. */
`timescale 1ns/10ps
module sasc_sequencer_test;
    reg mclk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg [7:0] avs_address_in = 8'h00;
    reg avs_read_in = 1'b0;
    reg avs_write_in = 1'b0;
    reg [31:0] avs_writedata_in = 32'h0;
    reg [3:0] avs_byteenable_in = 4'hf;
    reg debug_suspend_in = 1'b0;
    reg [1:0] fire = 2'b00;
    wire [31:0] avs_readdata_out;
    wire avs_waitrequest_out, single_insert, sequence_insert, conv_sample_out, conv_busy_out;
    wire conv_done_out, dma_req_out, single_done_irq_out, sequence_done_irq_out;
    wire conv_clk_en_out, power_up_out;
    wire [2:0] conv_channel_out, first_chan;
    wire [1:0] analog_power_out;
    wire [7:0] dma_cnt, irq1_cnt, irq2_cnt;
    logic [31:0] rdata;
    logic [7:0] d0;
    int n_errors = 0;
    int tests_run = 0;
    // ****
    // Clock, design and far side
    // ****
    always #2 mclk_in = ~mclk_in;
    sasc_sequencer sasc_sequencer_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .single_insert_in(single_insert),
        .sequence_insert_in(sequence_insert), .debug_suspend_in(debug_suspend_in),
        .conv_channel_out(conv_channel_out), .conv_sample_out(conv_sample_out),
        .conv_busy_out(conv_busy_out), .conv_done_out(conv_done_out),
        .dma_req_out(dma_req_out), .single_done_irq_out(single_done_irq_out),
        .sequence_done_irq_out(sequence_done_irq_out), .analog_power_out(analog_power_out),
        .power_up_out(power_up_out), .conv_clk_en_out(conv_clk_en_out));
    sasc_trigger_src sasc_trigger_src_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .fire_in(fire), .conv_channel_in(conv_channel_out), .conv_sample_in(conv_sample_out),
        .dma_req_in(dma_req_out), .single_done_irq_in(single_done_irq_out),
        .sequence_done_irq_in(sequence_done_irq_out), .single_insert_out(single_insert),
        .sequence_insert_out(sequence_insert), .first_chan_out(first_chan),
        .dma_cnt_out(dma_cnt), .irq1_cnt_out(irq1_cnt), .irq2_cnt_out(irq2_cnt));
    // ****
    // Shared tasks
    // ****
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is seen low; read data taken there
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_byteenable_in <= be;
        avs_write_in <= w;
        avs_read_in <= !w;
        @(posedge mclk_in);
        while (avs_waitrequest_out !== 1'b0 && n < 50) begin
            @(posedge mclk_in);
            n++;
        end
        rdata = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        chk({31'h0, n < 50}, 32'h1);
        @(posedge mclk_in);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(rdata & m, e);
    endtask
    task fire_pulse(input logic [1:0] f);
        fire <= f;
        @(posedge mclk_in);
        fire <= 2'b00;
        @(posedge mclk_in);
    endtask
    function logic [7:0] cnt(input int k);
        return k == 0 ? dma_cnt : (k == 1 ? irq1_cnt : irq2_cnt);
    endfunction
    // Bounded wait for the far side to count one more event
    task wait_inc(input int k);
        logic [7:0] c0;
        int n;
        c0 = cnt(k);
        n = 0;
        while (cnt(k) === c0 && n < 400) begin
            @(posedge mclk_in);
            n++;
        end
        chk({31'h0, n < 400}, 32'h1);
    endtask
    // ****
    // Scenarios
    // ****
    task t_reset;
        rd_chk(8'h00, 32'hffffffff, 32'h0);
        rd_chk(8'h04, 32'hffffffff, 32'h0);
        rd_chk(8'h74, 32'hffffffff, 32'h0);
        rd_chk(8'h50, 32'hffffffff, 32'h100);
        rd_chk(8'h40, 32'hffffffff, 32'h0);
    endtask
    task t_glob;
        int n;
        wr(8'h04, 32'hffffffff);
        rd_chk(8'h04, 32'hffffffff, 32'h33f);
        bus(1'b1, 8'h04, 32'h0, 4'h3);
        rd_chk(8'h04, 32'hffffffff, 32'h33f);
        rd_chk(8'h74, 32'h300, 32'h300);
        wr(8'h00, 32'h1);
        rd_chk(8'h00, 32'hffffffff, 32'h1);
        chk({31'h0, power_up_out}, 32'h1);
        chk({30'h0, analog_power_out}, 32'h3);
        wr(8'h04, 32'h303);
        n = 0;
        repeat (40) begin
            @(posedge mclk_in);
            if (conv_clk_en_out === 1'b1) n++;
        end
        chk(n, 32'd10);
        wr(8'h04, 32'h300);
    endtask
    task t_soft;
        d0 = dma_cnt;
        fire_pulse(2'b11);
        repeat (40) @(posedge mclk_in);
        chk(dma_cnt, d0);
        wr(8'h00, 32'h55);
        rd_chk(8'h00, 32'h4, 32'h4);
        rd_chk(8'h74, 32'h1, 32'h1);
        wait_inc(0);
        rd_chk(8'h00, 32'hffffffff, 32'h59);
        rd_chk(8'h00, 32'hffffffff, 32'h51);
        rd_chk(8'h74, 32'h3b, 32'h28);
    endtask
    task t_seq;
        wr(8'h18, 32'h1);
        wr(8'h08, 32'h3);
        wr(8'h0c, 32'h80);
        wr(8'h50, 32'h1);
        rd_chk(8'h50, 32'h301, 32'h1);
        wait_inc(0);
        fire_pulse(2'b01);
        wait_inc(1);
        chk(first_chan, 32'h3);
        wait_inc(0);
        fire_pulse(2'b11);
        wait_inc(2);
        chk(first_chan, 32'h3);
        wr(8'h08, 32'h203);
        wait_inc(0);
        d0 = dma_cnt;
        fire_pulse(2'b01);
        wait_inc(1);
        chk(8'(dma_cnt - d0), 32'h3);
    endtask
    task t_debug;
        debug_suspend_in <= 1'b1;
        repeat (40) @(posedge mclk_in);
        d0 = dma_cnt;
        fire_pulse(2'b01);
        repeat (60) @(posedge mclk_in);
        chk(dma_cnt, d0);
        wr(8'h50, 32'h0);
        wr(8'h00, 32'h35);
        wait_inc(0);
        rd_chk(8'h74, 32'h38, 32'h18);
        rd_chk(8'h00, 32'h8, 32'h8);
        debug_suspend_in <= 1'b0;
    endtask
    task t_stop_susp;
        wr(8'h50, 32'h1);
        wr(8'h50, 32'h0);
        rd_chk(8'h50, 32'h100, 32'h0);
        wait_inc(0);
        repeat (2) @(posedge mclk_in);
        rd_chk(8'h50, 32'h100, 32'h100);
        wr(8'h18, 32'h0);
        wr(8'h50, 32'h1);
        rd_chk(8'h50, 32'h301, 32'h201);
        d0 = dma_cnt;
        wr(8'h00, 32'h5);
        repeat (40) @(posedge mclk_in);
        chk(dma_cnt, d0);
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Watchdog well beyond the several hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge mclk_in);
        n_errors++;
        print_verdict();
    end
    // Reset for 16 cycles, then the scenarios in turn
    initial begin
        repeat (16) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(posedge mclk_in);
        t_reset();
        t_glob();
        t_soft();
        t_seq();
        t_debug();
        t_stop_susp();
        print_verdict();
    end
endmodule // sasc_sequencer_test
